// *** design/battery_current_accumulators.sv ***
// Purpose: offset correction, small-signal threshold and charge integration
// Assumes: adc converts on adc_start_o and answers with adc_done_i
// Notes:   configuration bits arrive as plain levels from the status logic
//
// Notes on behaviour
// - sample timer runs only while measurement enable is set, every 27.46 ms
// - each conversion finished while measurement enable is set, plus offset register, becomes the current result
// - net charge accumulator is 8 bits, moved up or down one step when summed samples cross a step
// - net charge accumulator holds while measurement enable is clear
// - one net accumulator step equals 0.4882 mVhr, unsigned bits 7..0
// - positive samples feed charge total, negative ones feed discharge total
// - only samples whose magnitude exceeds threshold are accumulated anywhere
// - threshold field in top two bits: none, 2, 4 or 8 lsb; low bits zero
// - threshold register is 00h after power-on
// - charge and discharge totals are 16-bit readable counters of 15.625 mVHr
// - enable off stops all; enable only runs net; both run lifetime too
// - page 07h is mapped to lifetime counters only while they are enabled
// - lifetime counters copied to eeprom only when shadow bit is set
// - lifetime totals keep their values when net accumulator reaches zero
`timescale 1ns/1ps
module battery_current_accumulators #(
	parameter int SAMPLE_CYC = batt_acc_pkg::SAMPLE_PERIOD_CYC
) (
	// clock and reset
	input  wire logic                     core_clk_i,
	input  wire logic                     rstn_i,
	// status and configuration levels
	input  wire logic                     current_meas_enable_i,
	input  wire logic                     lifetime_counters_enable_i,
	input  wire logic                     eeprom_shadow_enable_i,
	// current converter
	output logic                          adc_start_o,
	input  wire logic                     adc_done_i,
	input  wire logic [15:0]              adc_raw_i,
	// register port
	input  wire batt_acc_pkg::reg_req_t   reg_req_i,
	output logic                          reg_ack_o,
	output logic [15:0]                   reg_rdata_o,
	// memory page and eeprom shadow
	output logic                          page7_counters_mapped_o,
	output batt_acc_pkg::shadow_req_t     shadow_req_o
);

	// ------------------------------------------------------------
	// register port decode
	// ------------------------------------------------------------
	wire logic wr_offset    = reg_req_i.wr && (reg_req_i.idx == batt_acc_pkg::IDX_OFFSET);
	wire logic wr_net       = reg_req_i.wr && (reg_req_i.idx == batt_acc_pkg::IDX_NET);
	wire logic wr_thresh    = reg_req_i.wr && (reg_req_i.idx == batt_acc_pkg::IDX_THRESH);
	wire logic wr_charge    = reg_req_i.wr && (reg_req_i.idx == batt_acc_pkg::IDX_CHARGE);
	wire logic wr_discharge = reg_req_i.wr
		&& (reg_req_i.idx == batt_acc_pkg::IDX_DISCHARGE);

	// ------------------------------------------------------------
	// operating mode
	// ------------------------------------------------------------
	wire logic net_run  = current_meas_enable_i;
	wire logic life_run = current_meas_enable_i && lifetime_counters_enable_i;

	assign page7_counters_mapped_o = life_run;

	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	logic [15:0] offset_correction;
	logic [7:0]  small_signal_threshold;
	logic [7:0]  next_threshold;

	// only the two field bits are stored, the rest read as zero
	assign next_threshold = {reg_req_i.wdata[batt_acc_pkg::THR_HI_BIT],
		reg_req_i.wdata[batt_acc_pkg::THR_LO_BIT], 6'h00};

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			offset_correction      <= batt_acc_pkg::OFFSET_RST;
			small_signal_threshold <= batt_acc_pkg::THRESH_RST;
		end else begin
			if (wr_offset) begin
				offset_correction <= reg_req_i.wdata;
			end
			if (wr_thresh) begin
				small_signal_threshold <= next_threshold;
			end
		end
	end

	// ------------------------------------------------------------
	// background sampling
	// ------------------------------------------------------------
	sample_timer #(
		.PERIOD_CYC (SAMPLE_CYC)
	) u_timer (
		.core_clk_i (core_clk_i),
		.rstn_i     (rstn_i),
		.enable_i   (current_meas_enable_i),
		.tick_o     (adc_start_o)
	);

	// ------------------------------------------------------------
	// offset correction and threshold
	// ------------------------------------------------------------
	logic [15:0] current_result;
	logic        sample_valid;
	logic        sample_pass;
	logic [15:0] thr_mag;

	wire logic [15:0] corrected = adc_raw_i + offset_correction;
	wire logic        take_done = adc_done_i && current_meas_enable_i;
	wire logic [1:0]  thr_code  = small_signal_threshold[batt_acc_pkg::THR_HI_BIT
		-: 2];

	assign thr_mag = (thr_code == batt_acc_pkg::THR_2) ? batt_acc_pkg::THR_MAG_2
		: (thr_code == batt_acc_pkg::THR_4) ? batt_acc_pkg::THR_MAG_4
		: (thr_code == batt_acc_pkg::THR_8) ? batt_acc_pkg::THR_MAG_8
		: batt_acc_pkg::THR_MAG_NONE;

	// magnitude above threshold only; no threshold passes everything
	wire logic above = (thr_code == batt_acc_pkg::THR_NONE)
		|| (batt_acc_pkg::magnitude(corrected) > thr_mag);

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			current_result <= batt_acc_pkg::CURRENT_RST;
			sample_valid   <= 1'b0;
			sample_pass    <= 1'b0;
		end else begin
			if (take_done) begin
				current_result <= corrected;
			end
			sample_valid <= take_done;
			sample_pass  <= take_done && above;
		end
	end

	// ------------------------------------------------------------
	// accumulators, all fed from the same stored result
	// ------------------------------------------------------------
	logic [7:0]  net_charge_accumulator;
	logic [15:0] lifetime_charge_total;
	logic [15:0] lifetime_discharge_total;
	logic        charge_stepped;
	logic        discharge_stepped;

	charge_integrator #(
		.W    (batt_acc_pkg::NET_W),
		.STEP (batt_acc_pkg::NET_STEP_UNITS),
		.MODE (batt_acc_pkg::INT_NET)
	) u_net (
		.core_clk_i     (core_clk_i),
		.rstn_i         (rstn_i),
		.run_i          (net_run),
		.sample_valid_i (sample_pass),
		.sample_i       (current_result),
		.load_i         (wr_net),
		.load_value_i   (reg_req_i.wdata[7:0]),
		.count_o        (net_charge_accumulator),
		.stepped_o      ()
	);

	// lifetime totals see nothing of the net counter, so a drained net
	// counter leaves them untouched
	charge_integrator #(
		.W    (batt_acc_pkg::LIFE_W),
		.STEP (batt_acc_pkg::LIFE_STEP_UNITS),
		.MODE (batt_acc_pkg::INT_POS)
	) u_charge (
		.core_clk_i     (core_clk_i),
		.rstn_i         (rstn_i),
		.run_i          (life_run),
		.sample_valid_i (sample_pass),
		.sample_i       (current_result),
		.load_i         (wr_charge),
		.load_value_i   (reg_req_i.wdata),
		.count_o        (lifetime_charge_total),
		.stepped_o      (charge_stepped)
	);

	charge_integrator #(
		.W    (batt_acc_pkg::LIFE_W),
		.STEP (batt_acc_pkg::LIFE_STEP_UNITS),
		.MODE (batt_acc_pkg::INT_NEG)
	) u_discharge (
		.core_clk_i     (core_clk_i),
		.rstn_i         (rstn_i),
		.run_i          (life_run),
		.sample_valid_i (sample_pass),
		.sample_i       (current_result),
		.load_i         (wr_discharge),
		.load_value_i   (reg_req_i.wdata),
		.count_o        (lifetime_discharge_total),
		.stepped_o      (discharge_stepped)
	);

	// ------------------------------------------------------------
	// eeprom shadow
	// ------------------------------------------------------------
	wire logic shadow_now = life_run && eeprom_shadow_enable_i
		&& (charge_stepped || discharge_stepped);

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			shadow_req_o <= '0;
		end else begin
			shadow_req_o.valid <= shadow_now;
			if (shadow_now) begin
				shadow_req_o.charge    <= lifetime_charge_total;
				shadow_req_o.discharge <= lifetime_discharge_total;
			end
		end
	end

	// ------------------------------------------------------------
	// register read
	// ------------------------------------------------------------
	logic [15:0] rd_mux;

	assign rd_mux = (reg_req_i.idx == batt_acc_pkg::IDX_OFFSET) ? offset_correction
		: (reg_req_i.idx == batt_acc_pkg::IDX_CURRENT) ? current_result
		: (reg_req_i.idx == batt_acc_pkg::IDX_NET) ? {8'h00, net_charge_accumulator}
		: (reg_req_i.idx == batt_acc_pkg::IDX_THRESH) ? {8'h00, small_signal_threshold}
		: (reg_req_i.idx == batt_acc_pkg::IDX_CHARGE) ? lifetime_charge_total
		: (reg_req_i.idx == batt_acc_pkg::IDX_DISCHARGE) ? lifetime_discharge_total
		: batt_acc_pkg::RDATA_RST;

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			reg_rdata_o <= batt_acc_pkg::RDATA_RST;
			reg_ack_o   <= 1'b0;
		end else begin
			reg_ack_o <= reg_req_i.rd || reg_req_i.wr;
			if (reg_req_i.rd) begin
				reg_rdata_o <= rd_mux;
			end
		end
	end

endmodule : battery_current_accumulators

// *** design/charge_integrator.sv ***
// Purpose: integrates corrected samples into a scaled counter
// Assumes: one sample strobe per period, sample magnitude far below STEP
// Notes:   net mode counts both ways and saturates at both ends
`timescale 1ns/1ps
module charge_integrator #(
	parameter int                       W     = 8,
	parameter int                       STEP  = batt_acc_pkg::NET_STEP_UNITS,
	parameter batt_acc_pkg::int_mode_t  MODE  = batt_acc_pkg::INT_NET
) (
	// clock and reset
	input  wire logic         core_clk_i,
	input  wire logic         rstn_i,
	// sample stream
	input  wire logic         run_i,
	input  wire logic         sample_valid_i,
	input  wire logic [15:0]  sample_i,
	// host load
	input  wire logic         load_i,
	input  wire logic [W-1:0] load_value_i,
	// result
	output logic [W-1:0]      count_o,
	output logic              stepped_o
);
	localparam int RW = batt_acc_pkg::RESIDUE_W;
	localparam logic signed [RW-1:0] STEP_S = RW'(STEP);

	logic signed [RW-1:0] residue;
	logic signed [RW-1:0] delta;
	logic signed [RW-1:0] sum;
	logic signed [RW-1:0] next_residue;
	logic [W-1:0]         next_count;
	logic                 up;
	logic                 down;
	logic                 take;

	wire logic [15:0] mag = batt_acc_pkg::magnitude(sample_i);

	// charge-only and discharge-only follow the sign of the sample
	assign take  = run_i && sample_valid_i && (MODE == batt_acc_pkg::INT_NET
		|| (MODE == batt_acc_pkg::INT_POS && !sample_i[15] && sample_i != 16'h0000)
		|| (MODE == batt_acc_pkg::INT_NEG && sample_i[15]));
	assign delta = (MODE == batt_acc_pkg::INT_NET) ? RW'($signed(sample_i))
		: RW'(mag);
	assign sum   = residue + delta;
	assign up    = take && (sum >= STEP_S) && (count_o != {W{1'b1}});
	assign down  = take && (MODE == batt_acc_pkg::INT_NET) && (sum <= -STEP_S)
		&& (count_o != '0);

	assign next_residue = !take ? residue
		: (sum >= STEP_S)  ? sum - STEP_S
		: (sum <= -STEP_S) ? sum + STEP_S
		: sum;
	assign next_count = load_i ? load_value_i
		: up ? count_o + 1'b1
		: down ? count_o - 1'b1
		: count_o;

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			residue   <= '0;
			count_o   <= '0;
			stepped_o <= 1'b0;
		end else begin
			residue   <= load_i ? '0 : next_residue;
			count_o   <= next_count;
			stepped_o <= !load_i && (up || down);
		end
	end
endmodule : charge_integrator

// *** design/sample_timer.sv ***
// Purpose: background sample period generator
// Assumes: runs on the core clock, enable is synchronous
// Notes:   counter restarts whenever sampling is disabled
`timescale 1ns/1ps
module sample_timer #(
	parameter int PERIOD_CYC = batt_acc_pkg::SAMPLE_PERIOD_CYC
) (
	// clock and reset
	input  wire logic core_clk_i,
	input  wire logic rstn_i,
	// control
	input  wire logic enable_i,
	// period strobe
	output logic      tick_o
);
	localparam logic [batt_acc_pkg::TIMER_W-1:0] LAST =
		batt_acc_pkg::TIMER_W'(PERIOD_CYC - 1);

	logic [batt_acc_pkg::TIMER_W-1:0] count;
	logic [batt_acc_pkg::TIMER_W-1:0] next_count;
	wire                              at_last = (count == LAST);

	assign next_count = (!enable_i || at_last) ? '0 : count + 1'b1;
	assign tick_o     = enable_i && at_last;

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end
endmodule : sample_timer

// *** inc/batt_acc_pkg.sv ***
// Purpose: shared constants and types for the battery current accumulators
// Assumes: 25 MHz core clock
// Notes:   register indices are local to the documented register port
package batt_acc_pkg;

	// ------------------------------------------------------------
	// clock and timing
	// ------------------------------------------------------------
	localparam real CLK_PERIOD_NS       = 40.0;
	localparam real SAMPLE_PERIOD_MS    = 27.46;
	localparam int  SAMPLE_PERIOD_CYC   = int'($floor(SAMPLE_PERIOD_MS * 1.0e6 / CLK_PERIOD_NS));
	localparam int  TIMER_W             = 20;

	// ------------------------------------------------------------
	// scaling of the integrators
	// ------------------------------------------------------------
	localparam real CURRENT_LSB_MV      = 0.2441;
	localparam real NET_LSB_MVHR        = 0.4882;
	localparam real LIFE_LSB_MVHR       = 15.625;
	localparam real SEC_PER_HR          = 3600.0;
	localparam int  NET_STEP_UNITS      = int'(NET_LSB_MVHR * SEC_PER_HR
		/ (CURRENT_LSB_MV * SAMPLE_PERIOD_MS * 1.0e-3));
	localparam int  LIFE_STEP_UNITS     = int'(LIFE_LSB_MVHR * SEC_PER_HR
		/ (CURRENT_LSB_MV * SAMPLE_PERIOD_MS * 1.0e-3));
	localparam int  RESIDUE_W           = 32;

	// ------------------------------------------------------------
	// widths and reset values
	// ------------------------------------------------------------
	localparam int          DATA_W        = 16;
	localparam int          NET_W         = 8;
	localparam int          LIFE_W        = 16;
	localparam logic [15:0] OFFSET_RST    = 16'h0000;
	localparam logic [15:0] CURRENT_RST   = 16'h0000;
	localparam logic [7:0]  NET_RST       = 8'h00;
	localparam logic [7:0]  THRESH_RST    = 8'h00;
	localparam logic [15:0] LIFE_RST      = 16'h0000;
	localparam logic [15:0] RDATA_RST     = 16'h0000;

	// ------------------------------------------------------------
	// threshold field
	// ------------------------------------------------------------
	localparam int          THR_HI_BIT    = 7;
	localparam int          THR_LO_BIT    = 6;
	localparam logic [1:0]  THR_NONE      = 2'h0;
	localparam logic [1:0]  THR_2         = 2'h1;
	localparam logic [1:0]  THR_4         = 2'h2;
	localparam logic [1:0]  THR_8         = 2'h3;
	localparam logic [15:0] THR_MAG_NONE  = 16'h0000;
	localparam logic [15:0] THR_MAG_2     = 16'h0002;
	localparam logic [15:0] THR_MAG_4     = 16'h0004;
	localparam logic [15:0] THR_MAG_8     = 16'h0008;

	// ------------------------------------------------------------
	// register indices on the register port
	// ------------------------------------------------------------
	localparam logic [2:0] IDX_OFFSET     = 3'h0;
	localparam logic [2:0] IDX_CURRENT    = 3'h1;
	localparam logic [2:0] IDX_NET        = 3'h2;
	localparam logic [2:0] IDX_THRESH     = 3'h3;
	localparam logic [2:0] IDX_CHARGE     = 3'h4;
	localparam logic [2:0] IDX_DISCHARGE  = 3'h5;

	// ------------------------------------------------------------
	// integrator modes
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		INT_NET,
		INT_POS,
		INT_NEG
	} int_mode_t;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [2:0]  idx;
		logic [15:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic        valid;
		logic [15:0] charge;
		logic [15:0] discharge;
	} shadow_req_t;

	// magnitude of a two's complement sample
	function automatic logic [15:0] magnitude(input logic [15:0] v);
		magnitude = v[15] ? 16'(~v + 16'h0001) : v;
	endfunction : magnitude

endpackage : batt_acc_pkg

// *** verification/adc_partner.sv ***
// Purpose: behavioural current converter answering conversion requests
// Assumes: one conversion in flight, latency chosen by the bench
// Notes:   result lines toggle outside the done pulse so stale data never looks valid
`timescale 1ns/1ps
module adc_partner (
	// clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        rstn_i,
	// handshake
	input  wire logic        start_i,
	input  wire logic [3:0]  lat_i,
	input  wire logic [15:0] raw_val_i,
	output logic             done_o,
	output logic [15:0]      raw_o
);
	logic [3:0] cnt;
	wire logic  fire;
	assign fire = (start_i && lat_i == 4'h0) || cnt == 4'h1;
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt    <= 4'h0;
			done_o <= 1'b0;
			raw_o  <= 16'h0000;
		end else begin
			cnt    <= start_i ? lat_i : ((cnt != 4'h0) ? cnt - 4'h1 : 4'h0);
			done_o <= fire;
			raw_o  <= fire ? raw_val_i : ~raw_o;
		end
	end
endmodule : adc_partner

// *** verification/batt_acc_chk.sv ***
// Purpose: port-level assertions for the battery current accumulators
// Assumes: one core clock, asynchronous active-low reset
// Notes:   bound from the testbench top file
`timescale 1ns/1ps
module batt_acc_chk #(
	parameter int SAMPLE_CYC = 20
) (
	// clock and reset
	input wire logic                      core_clk_i,
	input wire logic                      rstn_i,
	// watched ports
	input wire logic                      current_meas_enable_i,
	input wire logic                      lifetime_counters_enable_i,
	input wire logic                      eeprom_shadow_enable_i,
	input wire logic                      adc_start_o,
	input wire logic                      adc_done_i,
	input wire logic [15:0]               adc_raw_i,
	input wire batt_acc_pkg::reg_req_t    reg_req_i,
	input wire logic                      reg_ack_o,
	input wire logic [15:0]               reg_rdata_o,
	input wire logic                      page7_counters_mapped_o,
	input wire batt_acc_pkg::shadow_req_t shadow_req_o
);
	int gap;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rstn_i);
	// cycles of enabled sampling since the last conversion request
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i)
			gap <= 0;
		else if (!current_meas_enable_i || adc_start_o)
			gap <= 0;
		else
			gap <= gap + 1;
	end
	ack_follow_a: assert property ((reg_req_i.wr || reg_req_i.rd) |=> reg_ack_o)
		else $error("access not acknowledged");
	ack_cause_a: assert property (reg_ack_o |-> $past(reg_req_i.wr || reg_req_i.rd))
		else $error("acknowledge without access");
	rdata_hold_a: assert property (!$past(reg_req_i.rd) |-> $stable(reg_rdata_o))
		else $error("read data moved without a read");
	thr_format_a: assert property (reg_req_i.rd
		&& reg_req_i.idx == batt_acc_pkg::IDX_THRESH
		|=> reg_rdata_o[15:8] == 8'h00 && reg_rdata_o[5:0] == 6'h00)
		else $error("threshold low bits not zero");
	page_map_a: assert property (page7_counters_mapped_o
		== (current_meas_enable_i && lifetime_counters_enable_i))
		else $error("page mapping wrong");
	start_gate_a: assert property (!current_meas_enable_i
		&& !$past(current_meas_enable_i) |-> !adc_start_o)
		else $error("conversion while disabled");
	start_period_a: assert property (adc_start_o
		|-> gap >= SAMPLE_CYC - 2 && gap <= SAMPLE_CYC)
		else $error("conversion period wrong");
	shadow_gate_a: assert property (shadow_req_o.valid
		|-> $past(eeprom_shadow_enable_i) && $past(lifetime_counters_enable_i, 2))
		else $error("shadow copy while not enabled");
	shadow_cause_a: assert property (shadow_req_o.valid
		|-> $past(adc_done_i, 3) && $past(current_meas_enable_i, 3))
		else $error("shadow copy without a sample");
	shadow_pulse_a: assert property (shadow_req_o.valid |=> !shadow_req_o.valid [*8])
		else $error("shadow copy repeated");
	cover property (reg_req_i.wr && reg_req_i.idx == batt_acc_pkg::IDX_THRESH);
	cover property (shadow_req_o.valid);
	cover property (adc_done_i && lifetime_counters_enable_i);
endmodule : batt_acc_chk

// *** verification/tb.sv ***
// Purpose: self-checking bench for the battery current accumulators
// Assumes: shortened sample period, converter modelled by adc_partner
// Notes:   an integer model tracks every register and residue, queueing shadow copies
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
	localparam int     SCYC  = 20;
	localparam longint NSTEP = batt_acc_pkg::NET_STEP_UNITS;
	localparam longint LSTEP = batt_acc_pkg::LIFE_STEP_UNITS;
	logic                      clk = 1'b0;
	logic                      rstn = 1'b0;
	logic                      meas = 1'b0;
	logic                      life = 1'b0;
	logic                      ee = 1'b0;
	logic                      start;
	logic                      done;
	logic [15:0]               raw;
	logic [15:0]               raw_val = 16'h0000;
	logic [3:0]                lat = 4'h0;
	batt_acc_pkg::reg_req_t    req = '0;
	logic                      ack;
	logic [15:0]               rdata;
	logic                      mapped;
	batt_acc_pkg::shadow_req_t shadow;
	logic [15:0]               off = 16'h0000, cur = 16'h0000, thr = 16'h0000, q;
	logic [15:0]               net = 16'h0000, chg = 16'h0000, dis = 16'h0000;
	longint                    rn = 0, rc = 0, rdr = 0;
	int                        n_errors = 0, checks_done = 0, cycles = 0;
	int                        n_sh_exp = 0, n_sh_got = 0;
	logic [31:0]               sh_q [$], sh_e;

	battery_current_accumulators #(.SAMPLE_CYC(SCYC)) battery_current_accumulators_i (
		.core_clk_i(clk), .rstn_i(rstn), .current_meas_enable_i(meas),
		.lifetime_counters_enable_i(life), .eeprom_shadow_enable_i(ee),
		.adc_start_o(start), .adc_done_i(done), .adc_raw_i(raw), .reg_req_i(req),
		.reg_ack_o(ack), .reg_rdata_o(rdata), .page7_counters_mapped_o(mapped),
		.shadow_req_o(shadow));
	adc_partner adc_partner_i (.core_clk_i(clk), .rstn_i(rstn), .start_i(start), .lat_i(lat),
		.raw_val_i(raw_val), .done_o(done), .raw_o(raw));

	always #20 clk = ~clk;

	task automatic print_verdict();
		$display("checks_done=%0d n_errors=%0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : print_verdict

	// ----------------------------------------------------------------
	// reference model
	// ----------------------------------------------------------------
	task automatic sample_model(input logic [15:0] r);
		longint s;
		longint m;
		cur = r + off;
		s = longint'($signed(cur));
		m = (s < 0) ? -s : s;
		if (m > ((thr[7:6] == 2'h0) ? 0 : (1 << thr[7:6]))) begin
			rn += s;
			if (rn >= NSTEP) begin
				rn -= NSTEP;
				net += (net < 16'h00ff);
			end else if (rn <= -NSTEP) begin
				rn += NSTEP;
				net -= (net > 16'h0000);
			end
			rc += (life && s > 0) ? s : 0;
			rdr += (life && s < 0) ? m : 0;
			n_sh_exp += ee && (rc >= LSTEP || rdr >= LSTEP);
			if (ee && (rc >= LSTEP || rdr >= LSTEP))
				sh_q.push_back({chg + 16'(rc >= LSTEP), dis + 16'(rdr >= LSTEP)});
			chg += (rc >= LSTEP);
			dis += (rdr >= LSTEP);
			rc -= (rc >= LSTEP) ? LSTEP : 0;
			rdr -= (rdr >= LSTEP) ? LSTEP : 0;
		end
	endtask : sample_model

	always @(posedge clk) begin
		if (done && meas)
			sample_model(raw);
		if (shadow.valid) begin
			n_sh_got++;
			sh_e = (sh_q.size() > 0) ? sh_q.pop_front() : 32'hffff_ffff;
			`CHK(shadow.charge, sh_e[31:16])
			`CHK(shadow.discharge, sh_e[15:0])
		end
	end

	// run is about 13500 cycles; over twice that means a hang
	always @(posedge clk) begin
		cycles++;
		if (cycles == 32000) begin
			n_errors++;
			print_verdict();
		end
	end

	// ----------------------------------------------------------------
	// stimulus tasks
	// ----------------------------------------------------------------
	task automatic access(input logic w, input logic [2:0] i, input logic [15:0] d);
		@(posedge clk);
		req <= {w, !w, i, d};
		@(posedge clk);
		req <= '0;
		#1;
		`CHK(ack, 1'b1)
		q = rdata;
		off = (w && i == 3'h0) ? d : off;
		thr = (w && i == 3'h3) ? (d & 16'h00c0) : thr;
		net = (w && i == 3'h2) ? {8'h00, d[7:0]} : net;
		chg = (w && i == 3'h4) ? d : chg;
		dis = (w && i == 3'h5) ? d : dis;
		rn = (w && i == 3'h2) ? 0 : rn;
		rc = (w && i == 3'h4) ? 0 : rc;
		rdr = (w && i == 3'h5) ? 0 : rdr;
	endtask : access

	function automatic logic [15:0] expv(input logic [2:0] i);
		logic [15:0] t [8];
		t = '{off, cur, net, thr, chg, dis, 16'h0000, 16'h0000};
		return t[i];
	endfunction : expv

	task automatic check_all();
		for (int i = 0; i < 8; i++) begin
			access(1'b0, 3'(i), 16'h0000);
			`CHK(q, expv(3'(i)))
		end
	endtask : check_all

	task automatic cfg(input logic m, input logic l, input logic e);
		@(posedge clk);
		meas <= m;
		life <= l;
		ee <= e;
	endtask : cfg

	task automatic feed(input int v);
		@(posedge clk);
		raw_val <= 16'(v) - off;
		lat <= 4'($urandom_range(0, 5));
		@(posedge clk iff start);
		@(posedge clk iff done);
		repeat (4) @(posedge clk);
	endtask : feed

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(11));
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		access(1'b0, 3'h3, 16'h0000);
		`CHK(q, 16'h0000)
		check_all();
		for (int i = 0; i < 8; i++)
			access(1'b1, 3'(i), 16'($urandom));
		check_all();
		access(1'b1, 3'h0, 16'h0000);
		access(1'b1, 3'h3, 16'h0000);
		cfg(1'b1, 1'b0, 1'b0);
		feed(int'($urandom_range(0, 200)) - 100);
		access(1'b0, 3'h1, 16'h0000);
		`CHK(q, cur)
		cfg(1'b0, 1'b0, 1'b0);
		access(1'b1, 3'h0, 16'h0000 - q);
		cfg(1'b1, 1'b0, 1'b0);
		feed(0);
		access(1'b0, 3'h1, 16'h0000);
		`CHK(q, 16'h0000)
		for (int c = 0; c < 4; c++) begin
			longint rem;
			int     sg;
			int     tm;
			sg = c[0] ? -1 : 1;
			tm = (c == 0) ? 0 : (1 << c);
			cfg(1'b0, 1'b1, 1'b0);
			access(1'b1, 3'h3, {8'h00, 2'(c), 6'h15});
			access(1'b1, 3'h0, 16'($signed(8'($urandom))));
			access(1'b1, 3'h2, (c == 3) ? 16'h0001 : 16'h0064);
			cfg(1'b1, 1'b1, 1'b0);
			rem = NSTEP - tm - 1;
			while (rem > 40000) begin
				feed(sg * 30000);
				rem -= 30000;
			end
			feed(sg * int'(rem / 2));
			feed(sg * int'(rem - rem / 2));
			feed(sg * tm);
			access(1'b0, 3'h2, 16'h0000);
			`CHK(q, net)
			feed(sg * (tm + 1));
			cfg(1'b0, 1'b1, 1'b0);
			check_all();
		end
		for (int m = 0; m < 3; m++) begin
			cfg(1'b0, 1'b0, 1'b0);
			access(1'b1, 3'h4, 16'($urandom_range(0, 32767)));
			access(1'b1, 3'h5, 16'($urandom_range(0, 32767)));
			access(1'b1, 3'h2, 16'h0080);
			cfg(1'b1, m > 0, m > 1);
			for (int k = 0; k < ((m == 0) ? 20 : 290); k++)
				feed((m == 2) ? -30000 : 30000);
			`CHK(mapped, 1'(m > 0))
			cfg(1'b0, m > 0, m > 1);
			check_all();
		end
		`CHK(n_sh_got, n_sh_exp)
		// net residue cleared and left one sample short of a step
		access(1'b1, 3'h2, 16'h0080);
		cfg(1'b1, 1'b0, 1'b0);
		for (int k = 0; k < 8; k++)
			feed(30000);
		@(posedge clk);
		raw_val <= 16'(30000) - off;
		lat <= 4'h6;
		@(posedge clk iff start);
		meas <= 1'b0;
		repeat (10) @(posedge clk);
		check_all();
		print_verdict();
	end
endmodule : tb

bind battery_current_accumulators batt_acc_chk #(.SAMPLE_CYC(SAMPLE_CYC)) batt_acc_chk_i (
	.core_clk_i(core_clk_i), .rstn_i(rstn_i), .current_meas_enable_i(current_meas_enable_i),
	.lifetime_counters_enable_i(lifetime_counters_enable_i),
	.eeprom_shadow_enable_i(eeprom_shadow_enable_i), .adc_start_o(adc_start_o),
	.adc_done_i(adc_done_i), .adc_raw_i(adc_raw_i), .reg_req_i(reg_req_i),
	.reg_ack_o(reg_ack_o), .reg_rdata_o(reg_rdata_o),
	.page7_counters_mapped_o(page7_counters_mapped_o), .shadow_req_o(shadow_req_o));
